// [verilog/rwdr_top.sv]
/*
  rwdr_top: watchdog relay, lamps and reset supervision of a rack supply module.
  assumes io writes and mode come from logic on CLK; reset terminal and rail
  levels are pins and are synchronised here.
*/
// Behaviour
// - the relay stays energised only while the watchdog address keeps being toggled fast enough.
// - a cpu fault or any mode other than run opens the relay and darkens the yellow lamp.
// - the yellow lamp is lit only while the user program is toggling the watchdog.
// - grounding the reset terminal puts the controller in reset within 2 ms in any state.
// - reset clears every digital output whatever the output-reset jumper says.
// - reset clears all timers and volatile flags.
// - the fast reset also clears the program step counter.
// - after any reset a cold start follows, never a warm restart.
// - reset is held while any monitored secondary rail is low, at switch-on and switch-off.
// - output enable is shown only while all io module supplies are present.
module rwdr_top
  import rwdr_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = WATCHDOG_TMO_CYC,
  parameter int unsigned FILT_CYC    = RST_FILT_CYC
) (
  // clock and reset
  input  wire logic                   CLK,
  input  wire logic                   RST_N,
  // cpu side
  input  wire rwdr_pkg::rwdr_iowr_s   IO_WR,
  input  wire rwdr_pkg::rwdr_mode_e   MODE,
  input  wire logic                   CPU_FAULT,
  input  wire logic                   RESET_OUT_JUMPER,
  // pins
  input  wire logic                   RESET_TERM_N,
  input  wire rwdr_pkg::rwdr_rails_s  RAILS_OK,
  input  wire logic                   IO_SUPPLY_OK,
  // outputs
  output logic                        SUPERVISION_RELAY,
  output logic                        WATCHDOG_LAMP,
  output logic                        OUT_ENABLE_LAMP,
  output logic                        CTRL_RESET,
  output rwdr_pkg::rwdr_rstact_s      RST_ACT
);
  import rwdr_pkg::*;

  localparam int unsigned TW = $clog2(TIMEOUT_CYC + 1);
  localparam int unsigned FW = $clog2(FILT_CYC + 1);

  // refuse counts that the counters cannot serve or that break the reset bound
  if (TIMEOUT_CYC < 2) begin : g_bad_timeout
    $error("rwdr_top: TIMEOUT_CYC too small");
  end
  if (FILT_CYC < 1 || FILT_CYC + 4 > RST_BOUND_CYC) begin : g_bad_filter
    $error("rwdr_top: FILT_CYC bad");
  end

  // pin levels through two flops
  logic [4:0] pins_s;
  rwdr_sync #(.W(5), .RST_VAL(5'h00)) u_sync (
    .clk   (CLK),
    .rst_n (RST_N),
    .d     ({~RESET_TERM_N, RAILS_OK.p24, RAILS_OK.p5, RAILS_OK.p15, IO_SUPPLY_OK}),
    .q     (pins_s)
  );
  wire term_low_s = pins_s[4];
  wire rails_good = &pins_s[3:1];
  wire io_sup_s   = pins_s[0];

  // reset terminal filter: a short glitch does not reset, a held low does
  logic [FW-1:0] filt_cnt_r;
  logic [FW-1:0] filt_cnt_nxt;
  wire filt_full = (filt_cnt_r == FW'(FILT_CYC));
  assign filt_cnt_nxt = !term_low_s ? '0 : (filt_full ? filt_cnt_r : filt_cnt_r + 1'b1);
  always_ff @(posedge CLK) begin
    if (!RST_N) filt_cnt_r <= '0;
    else        filt_cnt_r <= filt_cnt_nxt;
  end

  // reset request: terminal held or any rail low
  wire rst_req = filt_full | !rails_good;

  // separate count of how long the terminal has read low, kept apart from the
  // filter so the bound check does not lean on the logic that it judges
  localparam int unsigned HW = $clog2(FILT_CYC + 2);
  logic [HW-1:0] low_run_r;
  logic [HW-1:0] low_run_nxt;
  wire           low_run_top = (low_run_r == HW'(FILT_CYC + 1));
  assign low_run_nxt = !term_low_s ? '0 : (low_run_top ? low_run_r : low_run_r + 1'b1);
  always_ff @(posedge CLK) begin
    if (!RST_N) low_run_r <= '0;
    else        low_run_r <= low_run_nxt;
  end

  // watchdog address decode in any rack unit
  wire sup_addr_hit = IO_WR.valid && ((IO_WR.addr & WATCHDOG_ADDR_MASK) == WATCHDOG_ADDR_LOW);
  logic last_bit_r;
  wire  toggle = sup_addr_hit && (IO_WR.data != last_bit_r);
  wire  run_ok = (MODE == RWDR_MODE_RUN) && !CPU_FAULT && !CTRL_RESET;

  // retriggerable timeout counter, zero means expired
  logic [TW-1:0] tmo_r;
  logic [TW-1:0] tmo_nxt;
  assign tmo_nxt = (!run_ok) ? '0 :
                   toggle ? TW'(TIMEOUT_CYC) :
                   (tmo_r != '0) ? tmo_r - 1'b1 : '0;
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      tmo_r      <= '0;
      last_bit_r <= 1'b0;
    end else begin
      tmo_r      <= tmo_nxt;
      if (sup_addr_hit) last_bit_r <= IO_WR.data;
    end
  end

  // relay and lamp follow the live timeout; lamp shares the relay drive
  wire relay_nxt = run_ok && (tmo_nxt != '0);

  // relay and lamp drive; one source so the contact and the lamp can never disagree
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      SUPERVISION_RELAY <= 1'b0;
      WATCHDOG_LAMP     <= 1'b0;
    end else begin
      SUPERVISION_RELAY <= relay_nxt;
      WATCHDOG_LAMP     <= relay_nxt;
    end
  end

  // output enable lamp; a low rail also counts as a missing io supply
  always_ff @(posedge CLK) begin
    if (!RST_N) OUT_ENABLE_LAMP <= 1'b0;
    else        OUT_ENABLE_LAMP <= io_sup_s && rails_good;
  end

  // controller reset level, plus a delayed copy to find its release edge
  logic ctrl_reset_d_r;
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      CTRL_RESET     <= 1'b1;
      ctrl_reset_d_r <= 1'b1;
    end else begin
      CTRL_RESET     <= rst_req;
      ctrl_reset_d_r <= CTRL_RESET;
    end
  end

  // clear strobes follow the request level; cold start marks the release only,
  // so there is no path to a warm restart at all
  // the output-reset jumper is left out of every clear term on purpose
  rwdr_rstact_s rst_act_nxt;
  wire          cold_nxt = ctrl_reset_d_r && !CTRL_RESET;
  assign rst_act_nxt = '{clr_outputs: rst_req,
                         clr_timers:  rst_req,
                         clr_flags:   rst_req,
                         clr_step:    rst_req,
                         cold_start:  cold_nxt};
  always_ff @(posedge CLK) begin
    if (!RST_N) RST_ACT <= '{default: 1'b1};
    else        RST_ACT <= rst_act_nxt;
  end

  // watchdog relay and lamp
  chk_relay_needs_run: assert property (@(posedge CLK) disable iff (!RST_N)
    (MODE != RWDR_MODE_RUN || CPU_FAULT) |=> !SUPERVISION_RELAY)
    else $error("relay closed outside run");
  chk_reset_opens_relay: assert property (@(posedge CLK) disable iff (!RST_N)
    CTRL_RESET |=> !SUPERVISION_RELAY)
    else $error("relay closed during reset");
  chk_lamp_tracks_relay: assert property (@(posedge CLK) disable iff (!RST_N)
    WATCHDOG_LAMP == SUPERVISION_RELAY)
    else $error("lamp and relay differ");
  chk_lamp_needs_toggle: assert property (@(posedge CLK) disable iff (!RST_N)
    (tmo_r == '0 && !toggle) |=> !WATCHDOG_LAMP)
    else $error("lamp lit with no toggle running");
  chk_toggle_closes: assert property (@(posedge CLK) disable iff (!RST_N)
    (toggle && run_ok && MODE == RWDR_MODE_RUN && !CPU_FAULT) |=> SUPERVISION_RELAY)
    else $error("toggle did not close relay");
  chk_timeout_drop: assert property (@(posedge CLK) disable iff (!RST_N)
    (tmo_r == TW'(1) && !toggle) |=> !SUPERVISION_RELAY)
    else $error("relay held after timeout");

  // reset supervision
  chk_reset_bound: assert property (@(posedge CLK) disable iff (!RST_N)
    low_run_top |-> CTRL_RESET)
    else $error("reset terminal not honoured");
  chk_rail_reset: assert property (@(posedge CLK) disable iff (!RST_N)
    !rails_good |=> CTRL_RESET && RST_ACT.clr_outputs && RST_ACT.clr_step)
    else $error("rail low without reset");
  chk_clear_all: assert property (@(posedge CLK) disable iff (!RST_N)
    CTRL_RESET |-> RST_ACT.clr_timers && RST_ACT.clr_flags)
    else $error("timers or flags not cleared");
  chk_jumper_ignored: assert property (@(posedge CLK) disable iff (!RST_N)
    (rst_req && RESET_OUT_JUMPER) |=> RST_ACT.clr_outputs)
    else $error("jumper kept outputs in reset");
  chk_term_clears_step: assert property (@(posedge CLK) disable iff (!RST_N)
    filt_full |=> RST_ACT.clr_step && RST_ACT.clr_outputs)
    else $error("terminal reset kept the step counter");
  chk_cold_start: assert property (@(posedge CLK) disable iff (!RST_N)
    $fell(CTRL_RESET) |=> RST_ACT.cold_start ##1 !RST_ACT.cold_start)
    else $error("no cold start pulse");
  chk_release_clear: assert property (@(posedge CLK) disable iff (!RST_N)
    $fell(CTRL_RESET) |-> !RST_ACT.clr_outputs && !RST_ACT.clr_timers && !RST_ACT.clr_step)
    else $error("clear strobes outlive reset");

  // output enable lamp
  chk_out_enable: assert property (@(posedge CLK) disable iff (!RST_N)
    !io_sup_s |=> !OUT_ENABLE_LAMP)
    else $error("output enable without supply");
  chk_oe_needs_rails: assert property (@(posedge CLK) disable iff (!RST_N)
    !rails_good |=> !OUT_ENABLE_LAMP)
    else $error("output enable with a rail low");
  chk_oe_with_supply: assert property (@(posedge CLK) disable iff (!RST_N)
    (io_sup_s && rails_good) |=> OUT_ENABLE_LAMP)
    else $error("output enable dark with supplies");

  // main scenarios
  cov_relay_on: cover property (@(posedge CLK) disable iff (!RST_N) $rose(SUPERVISION_RELAY));
  cov_relay_timeout: cover property (@(posedge CLK) disable iff (!RST_N)
    $fell(SUPERVISION_RELAY) && MODE == RWDR_MODE_RUN);
  cov_term_reset: cover property (@(posedge CLK) disable iff (!RST_N) filt_full);
  cov_cold: cover property (@(posedge CLK) disable iff (!RST_N) RST_ACT.cold_start);
  cov_jumper_reset: cover property (@(posedge CLK) disable iff (!RST_N) RESET_OUT_JUMPER && CTRL_RESET);
endmodule // rwdr_top

// [verilog/rwdr_pkg.sv]
/*
  rwdr_pkg: constants and carrier types for the rack watchdog and reset block.
  assumes a single 250 MHz clock; every time figure is turned into cycles here.
*/
package rwdr_pkg;
  // clock rate
  localparam int unsigned CLK_HZ           = 250_000_000;
  // watchdog address within each rack unit, and the mask that keeps only its in-unit low byte
  localparam logic [15:0] WATCHDOG_ADDR_LOW  = 16'h00FF;
  localparam logic [15:0] WATCHDOG_ADDR_MASK = 16'h00FF;
  // longest gap between two toggles before the relay drops, in ms
  localparam int unsigned WATCHDOG_TMO_MS    = 200;
  localparam int unsigned WATCHDOG_TMO_CYC   = (CLK_HZ / 1000) * WATCHDOG_TMO_MS;
  // longest time from reset terminal to reset, in ms (rounded down)
  localparam int unsigned RST_BOUND_MS     = 2;
  localparam int unsigned RST_BOUND_CYC    = (CLK_HZ / 1000) * RST_BOUND_MS;
  // filter length on the reset terminal, well inside the bound
  localparam int unsigned RST_FILT_CYC     = 16;
  // operating modes
  typedef enum logic [1:0] {RWDR_MODE_RUN, RWDR_MODE_HALT, RWDR_MODE_STOP, RWDR_MODE_STEP}
    rwdr_mode_e;
  // one write from the cpu onto the rack io bus
  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
    logic        data;
  } rwdr_iowr_s;
  // monitored secondary rails, high while good
  typedef struct packed {
    logic p24;
    logic p5;
    logic p15;
  } rwdr_rails_s;
  // reset actions driven into the controller
  typedef struct packed {
    logic clr_outputs;
    logic clr_timers;
    logic clr_flags;
    logic clr_step;
    logic cold_start;
  } rwdr_rstact_s;
endpackage : rwdr_pkg

// [verilog/rwdr_sync.sv]
/*
  rwdr_sync: two flip-flop synchroniser for a vector of pin levels.
  assumes the inputs are asynchronous levels; reset value is a parameter.
*/
module rwdr_sync #(
  parameter int unsigned W         = 1,
  parameter logic [W-1:0] RST_VAL  = '0
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  // a zero-wide vector has nothing to carry
  if (W < 1) begin : g_bad_width
    $error("rwdr_sync: W must be at least 1");
  end

  // the first stage is read by the second stage only
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_r <= RST_VAL;
      q      <= RST_VAL;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule // rwdr_sync

// [tb/rwdr_cpu_model.sv]
/*
  rwdr_cpu_model: user program on the cpu, one io write burst per cyclic pass.
  assumes the block samples io writes on the same rising clock edge.
*/
module rwdr_cpu_model
  import rwdr_pkg::*;
#(
  parameter int unsigned PASS_CYC = 20
) (
  // clock
  input  wire logic            clk,
  // program running its cyclic block
  input  wire logic            run,
  // writes onto the rack io bus
  output rwdr_pkg::rwdr_iowr_s io_wr
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned cnt = 0;
  logic        acc = 1'b0;
  // each pass complements the watchdog bit, then writes a plain output elsewhere
  always @(posedge clk) begin
    cnt   <= (cnt == PASS_CYC - 1) ? 0 : cnt + 1;
    io_wr <= '0;
    if (run && cnt == 0) begin
      acc   <= ~acc;
      io_wr <= '{valid: 1'b1, addr: 16'h01FF, data: ~acc};
    end else if (run && cnt == 1) begin
      io_wr <= '{valid: 1'b1, addr: 16'h0010, data: acc};
    end
  end
endmodule // rwdr_cpu_model

// [tb/test_rack_watchdog_and_reset.sv]
/*
  test_rack_watchdog_and_reset: scenario bench for the watchdog and reset block.
  assumes rwdr_pkg and rwdr_top compiled first; timeout shortened to 100 cycles.
*/
module test_rack_watchdog_and_reset import rwdr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned TO_CYC = 100;
  logic         CLK = 1'b0, RST_N = 1'b0, fault = 1'b0, jumper = 1'b0;
  logic         term_n = 1'b1, io_ok = 1'b1, run = 1'b0;
  rwdr_mode_e   mode = RWDR_MODE_RUN;
  rwdr_rails_s  rails = 3'b111;
  rwdr_iowr_s   io_wr;
  logic         relay, lamp, oe_lamp, ctrl_rst;
  rwdr_rstact_s act;
  int           err_total = 0, tests_run = 0;
  // 250 MHz clock
  always #2 CLK = ~CLK;
  rwdr_cpu_model #(.PASS_CYC(20)) i_rwdr_cpu_model (.clk(CLK), .run(run), .io_wr(io_wr));
  rwdr_top #(.TIMEOUT_CYC(TO_CYC), .FILT_CYC(RST_FILT_CYC)) i_rwdr_top (
    .CLK(CLK), .RST_N(RST_N), .IO_WR(io_wr), .MODE(mode), .CPU_FAULT(fault),
    .RESET_OUT_JUMPER(jumper), .RESET_TERM_N(term_n), .RAILS_OK(rails),
    .IO_SUPPLY_OK(io_ok), .SUPERVISION_RELAY(relay), .WATCHDOG_LAMP(lamp),
    .OUT_ENABLE_LAMP(oe_lamp), .CTRL_RESET(ctrl_rst), .RST_ACT(act));
  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic ok, input string msg);
    tests_run++;
    if (!ok) begin
      $display("unexpected at %0t: %s", $time, msg);
      err_total++;
    end
  endtask
  // settle one step past the edge so registered outputs have landed
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask
  function automatic logic pick(input int w);
    case (w)
      0:       return relay;
      1:       return ctrl_rst;
      default: return act.cold_start;
    endcase
  endfunction
  // bounded wait; running out ends the run as a mismatch
  task automatic wait_lvl(input int w, input logic v, input int lim);
    int n;
    n = 0;
    while (pick(w) !== v && n < lim) begin
      cyc(1);
      n++;
    end
    chk(pick(w) === v, "wait ran out");
    if (pick(w) !== v) end_of_test();
  endtask
  task automatic t_cold();
    wait_lvl(1, 1'b0, 40);
    wait_lvl(2, 1'b1, 3);
    cyc(1);
    chk(act.cold_start === 1'b0, "cold start pulse too long");
  endtask
  task automatic t_watchdog();
    @(posedge CLK) run <= 1'b1;
    wait_lvl(0, 1'b1, 30);
    chk(lamp === 1'b1, "lamp dark while toggling");
    cyc(3 * TO_CYC);
    chk(relay === 1'b1 && lamp === 1'b1, "relay dropped while toggling");
    @(posedge CLK) run <= 1'b0;
    cyc(TO_CYC - 25);
    chk(relay === 1'b1, "relay dropped before timeout");
    wait_lvl(0, 1'b0, 40);
    chk(lamp === 1'b0, "lamp lit without toggles");
  endtask
  // index 0 is a cpu fault, the rest are the modes other than run
  task automatic t_stop();
    @(posedge CLK) run <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wait_lvl(0, 1'b1, 30);
      @(posedge CLK);
      if (i == 0) fault <= 1'b1;
      else mode <= rwdr_mode_e'(i);
      wait_lvl(0, 1'b0, 3);
      cyc(40);
      chk(relay === 1'b0 && lamp === 1'b0, "relay closed outside run");
      @(posedge CLK) fault <= 1'b0;
      mode <= RWDR_MODE_RUN;
    end
  endtask
  task automatic t_term();
    for (int j = 0; j < 2; j++) begin
      wait_lvl(0, 1'b1, 30);
      @(posedge CLK) jumper <= j[0];
      term_n <= 1'b0;
      wait_lvl(1, 1'b1, RST_FILT_CYC + 8);
      cyc(2);
      chk(act.clr_outputs === 1'b1 && relay === 1'b0, "outputs kept in reset");
      chk(act.clr_timers === 1'b1 && act.clr_flags === 1'b1, "timers kept");
      chk(act.clr_step === 1'b1, "step counter kept");
      @(posedge CLK) term_n <= 1'b1;
      t_cold();
    end
    @(posedge CLK) term_n <= 1'b0;
    cyc(RST_FILT_CYC / 2);
    @(posedge CLK) term_n <= 1'b1;
    cyc(30);
    chk(ctrl_rst === 1'b0, "short terminal pulse taken as reset");
  endtask
  task automatic t_rails();
    for (int r = 0; r < 3; r++) begin
      @(posedge CLK) rails <= 3'b111 ^ (3'b001 << r);
      wait_lvl(1, 1'b1, 6);
      cyc(3);
      chk(oe_lamp === 1'b0, "output enable with a rail low");
      @(posedge CLK) rails <= 3'b111;
      t_cold();
    end
    @(posedge CLK) io_ok <= 1'b0;
    cyc(5);
    chk(oe_lamp === 1'b0 && ctrl_rst === 1'b0, "output enable without io supply");
    @(posedge CLK) io_ok <= 1'b1;
    cyc(5);
    chk(oe_lamp === 1'b1, "output enable dark with supplies");
  endtask
  // main sequence
  initial begin
    repeat (10) @(posedge CLK);
    RST_N <= 1'b1;
    t_cold();
    t_watchdog();
    t_stop();
    t_term();
    t_rails();
    end_of_test();
  end
endmodule // test_rack_watchdog_and_reset
